/* File: rtl/pfc_consts.svh */
/*
 * Constants of the parallel flash command port host: timing counts at the
 * 250 MHz CLOCK, command addresses and command values.
 * Assumes inclusion by bare name from the host module.
 */
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

`define PFC_CLK_PERIOD_NS 4
`define PFC_WP_NS 50
`define PFC_WPH_NS 40
`define PFC_TOGGLE_HI_NS 150
`define PFC_ACC_NS 45
`define PFC_WP_CYC ((`PFC_WP_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_WPH_CYC ((`PFC_WPH_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_TOGGLE_HI_CYC ((`PFC_TOGGLE_HI_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_ACC_CYC ((`PFC_ACC_NS + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_SYNC_CYC 2
`define PFC_CNT_W 6

`define PFC_ADDR_555 12'h555
`define PFC_ADDR_AAA 12'hAAA
`define PFC_ADDR_EXIT 12'h000
`define PFC_DAT_UNLOCK1 8'hAA
`define PFC_DAT_UNLOCK2 8'h55
`define PFC_DAT_ID_ENTRY 8'h90
`define PFC_DAT_ID_EXIT 8'hF0
`define PFC_DAT_PROG 8'hA0
`define PFC_DAT_ERASE 8'h80
`define PFC_DAT_CHIP_ERASE 8'h10
`define PFC_DAT_MAIN_ERASE 8'h30
`define PFC_TOGGLE_BIT 6

`endif

/* File: rtl/pfc_pkg.sv */
/*
 * Types of the parallel flash command port host.
 * Assumes pfc_consts.svh on the include path.
 */
package pfc_pkg;
    typedef enum logic [2:0] {
        PFC_OP_READ = 3'h0,
        PFC_OP_PROG = 3'h1,
        PFC_OP_ID_ENTRY = 3'h2,
        PFC_OP_ID_EXIT = 3'h3,
        PFC_OP_CHIP_ERASE = 3'h4,
        PFC_OP_MAIN_ERASE = 3'h5,
        PFC_OP_ID_READ = 3'h6
    } pfc_op_type;

    typedef enum logic [2:0] {
        PFC_ST_IDLE = 3'h0,
        PFC_ST_WR_LO = 3'h1,
        PFC_ST_WR_HI = 3'h3,
        PFC_ST_RD_LO = 3'h2,
        PFC_ST_RD_HI = 3'h6
    } pfc_state_type;
endpackage : pfc_pkg

/* File: rtl/pfc_host.sv */
/*
 * Host controller that drives a 16-bit parallel flash through its pins:
 * reads, identification reads, command sequences, word program, erase,
 * and toggle-bit completion polling.
 * Assumes a clockless flash on the pins and a user on the CLOCK domain.
 */
// Function
// - command value only in low data byte
// - only low twelve address bits decoded
// - AA@555, 55@AAA, 90@555 enters identification
// - erase final value 10 chip, 30 main
// - output enable high during erase writes
// - toggle reads: high phase at least 150 ns
// - no assumed toggle bit level
// - constant address during whole polling sequence
// - F0 at any address exits identification
`timescale 1ns/100ps
`include "pfc_consts.svh"

module pfc_host (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire pfc_pkg::pfc_op_type CMD_OP,
    input wire logic [15:0] CMD_ADDR,
    input wire logic [15:0] CMD_DATA,
    output logic CMD_DONE,
    output logic RSP_VALID,
    output logic [15:0] RSP_DATA,
    output logic ID_MODE,
    output logic [15:0] FL_ADDR,
    output logic FL_CE_N,
    output logic FL_OE_N,
    output logic FL_WE_N,
    input wire logic [15:0] FL_DQ_IN,
    output logic [15:0] FL_DQ_OUT,
    output logic FL_DQ_OE
);
    localparam logic [5:0] WP_LAST = 6'(`PFC_WP_CYC - 1);
    localparam logic [5:0] WPH_LAST = 6'(`PFC_WPH_CYC - 1);
    localparam logic [5:0] RD_LAST = 6'(`PFC_ACC_CYC + `PFC_SYNC_CYC - 1);
    localparam logic [5:0] TH_LAST = 6'(`PFC_TOGGLE_HI_CYC - 1);

    // number of write cycles of a command sequence
    function automatic logic [2:0] seq_len(input pfc_pkg::pfc_op_type op);
        unique case (op)
            pfc_pkg::PFC_OP_PROG: seq_len = 3'h4;
            pfc_pkg::PFC_OP_ID_ENTRY: seq_len = 3'h3;
            pfc_pkg::PFC_OP_ID_EXIT: seq_len = 3'h1;
            pfc_pkg::PFC_OP_CHIP_ERASE, pfc_pkg::PFC_OP_MAIN_ERASE: seq_len = 3'h6;
            default: seq_len = 3'h0;
        endcase
    endfunction : seq_len

    // address and data of one write cycle: {addr, data}
    function automatic logic [31:0] cyc_word(input pfc_pkg::pfc_op_type op, input logic [2:0] idx,
                                             input logic [15:0] a, input logic [15:0] d);
        logic [19:0] w;
        w = {`PFC_ADDR_555, `PFC_DAT_UNLOCK1};
        if (op == pfc_pkg::PFC_OP_ID_EXIT) begin
            w = {`PFC_ADDR_EXIT, `PFC_DAT_ID_EXIT};
        end else begin
            unique case (idx)
                3'h1, 3'h4: w = {`PFC_ADDR_AAA, `PFC_DAT_UNLOCK2};
                3'h2: begin
                    if (op == pfc_pkg::PFC_OP_ID_ENTRY) begin
                        w = {`PFC_ADDR_555, `PFC_DAT_ID_ENTRY};
                    end else if (op == pfc_pkg::PFC_OP_PROG) begin
                        w = {`PFC_ADDR_555, `PFC_DAT_PROG};
                    end else begin
                        w = {`PFC_ADDR_555, `PFC_DAT_ERASE};
                    end
                end
                3'h5: w = {`PFC_ADDR_555, (op == pfc_pkg::PFC_OP_CHIP_ERASE) ?
                           `PFC_DAT_CHIP_ERASE : `PFC_DAT_MAIN_ERASE};
                default: w = {`PFC_ADDR_555, `PFC_DAT_UNLOCK1};
            endcase
        end
        if (op == pfc_pkg::PFC_OP_PROG && idx == 3'h3) begin
            cyc_word = {a, d};
        end else begin
            cyc_word = {4'h0, w[19:8], 8'h00, w[7:0]};
        end
    endfunction : cyc_word

    // pin input synchroniser
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            dq_s1 <= 16'h0000;
            dq_s2 <= 16'h0000;
        end else begin
            dq_s1 <= FL_DQ_IN;
            dq_s2 <= dq_s1;
        end
    end

    pfc_pkg::pfc_state_type state, next_state;
    pfc_pkg::pfc_op_type op, next_op;
    logic [5:0] cnt, next_cnt;
    logic [2:0] step, next_step;
    logic [15:0] addr, next_addr;
    logic [15:0] data, next_data;
    logic prev6, next_prev6;
    logic have_prev, next_have_prev;
    logic fin, next_fin;
    logic id_mode, next_id_mode;
    logic done, next_done;
    logic rsp_valid, next_rsp_valid;
    logic [15:0] rsp_data, next_rsp_data;
    logic [15:0] pin_addr, next_pin_addr;
    logic [15:0] pin_dq, next_pin_dq;
    logic ce_n, next_ce_n;
    logic oe_n, next_oe_n;
    logic we_n, next_we_n;
    logic dq_oe, next_dq_oe;
    logic poll_op;
    logic [31:0] word;

    assign poll_op = (op == pfc_pkg::PFC_OP_PROG) || (op == pfc_pkg::PFC_OP_CHIP_ERASE)
                     || (op == pfc_pkg::PFC_OP_MAIN_ERASE);

    always_comb begin
        next_state = state;
        next_op = op;
        next_cnt = cnt + 6'h01;
        next_step = step;
        next_addr = addr;
        next_data = data;
        next_prev6 = prev6;
        next_have_prev = have_prev;
        next_fin = fin;
        next_id_mode = id_mode;
        next_done = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_pin_addr = pin_addr;
        next_pin_dq = pin_dq;
        next_ce_n = ce_n;
        next_oe_n = oe_n;
        next_we_n = we_n;
        next_dq_oe = dq_oe;
        word = cyc_word(op, step + 3'h1, addr, data);
        unique case (state)
            pfc_pkg::PFC_ST_IDLE: begin
                next_cnt = 6'h00;
                word = cyc_word(CMD_OP, 3'h0, CMD_ADDR, CMD_DATA);
                if (CMD_VALID) begin
                    next_op = CMD_OP;
                    next_step = 3'h0;
                    next_data = CMD_DATA;
                    next_have_prev = 1'b0;
                    next_addr = CMD_ADDR;
                    next_ce_n = 1'b0;
                    if (CMD_OP == pfc_pkg::PFC_OP_READ || CMD_OP == pfc_pkg::PFC_OP_ID_READ) begin
                        if (CMD_OP == pfc_pkg::PFC_OP_ID_READ) begin
                            next_addr = {15'h0000, CMD_ADDR[0]};
                        end
                        next_pin_addr = next_addr;
                        next_oe_n = 1'b0;
                        next_fin = 1'b1;
                        next_state = pfc_pkg::PFC_ST_RD_LO;
                    end else begin
                        next_pin_addr = word[31:16];
                        next_pin_dq = word[15:0];
                        next_dq_oe = 1'b1;
                        next_we_n = 1'b0;
                        next_state = pfc_pkg::PFC_ST_WR_LO;
                    end
                end
            end
            pfc_pkg::PFC_ST_WR_LO: begin
                if (cnt == WP_LAST) begin
                    next_cnt = 6'h00;
                    next_we_n = 1'b1;
                    next_ce_n = 1'b1;
                    next_state = pfc_pkg::PFC_ST_WR_HI;
                end
            end
            pfc_pkg::PFC_ST_WR_HI: begin
                if (cnt == WPH_LAST) begin
                    next_cnt = 6'h00;
                    if (step == seq_len(op) - 3'h1) begin
                        next_dq_oe = 1'b0;
                        if (op == pfc_pkg::PFC_OP_ID_ENTRY) begin
                            next_id_mode = 1'b1;
                        end
                        if (op == pfc_pkg::PFC_OP_ID_EXIT) begin
                            next_id_mode = 1'b0;
                        end
                        if (poll_op) begin
                            next_pin_addr = addr;
                            next_fin = 1'b0;
                            next_ce_n = 1'b0;
                            next_oe_n = 1'b0;
                            next_state = pfc_pkg::PFC_ST_RD_LO;
                        end else begin
                            next_done = 1'b1;
                            next_state = pfc_pkg::PFC_ST_IDLE;
                        end
                    end else begin
                        next_step = step + 3'h1;
                        next_pin_addr = word[31:16];
                        next_pin_dq = word[15:0];
                        next_we_n = 1'b0;
                        next_ce_n = 1'b0;
                        next_state = pfc_pkg::PFC_ST_WR_LO;
                    end
                end
            end
            pfc_pkg::PFC_ST_RD_LO: begin
                if (cnt == RD_LAST) begin
                    next_cnt = 6'h00;
                    next_rsp_data = dq_s2;
                    next_prev6 = dq_s2[`PFC_TOGGLE_BIT];
                    next_have_prev = 1'b1;
                    if (poll_op && have_prev && dq_s2[`PFC_TOGGLE_BIT] == prev6) begin
                        next_fin = 1'b1;
                    end
                    next_oe_n = 1'b1;
                    next_ce_n = 1'b1;
                    next_state = pfc_pkg::PFC_ST_RD_HI;
                end
            end
            pfc_pkg::PFC_ST_RD_HI: begin
                if (cnt == TH_LAST) begin
                    next_cnt = 6'h00;
                    if (fin) begin
                        next_done = 1'b1;
                        next_rsp_valid = !poll_op;
                        next_state = pfc_pkg::PFC_ST_IDLE;
                    end else begin
                        next_oe_n = 1'b0;
                        next_ce_n = 1'b0;
                        next_state = pfc_pkg::PFC_ST_RD_LO;
                    end
                end
            end
            default: begin
                next_state = pfc_pkg::PFC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state <= pfc_pkg::PFC_ST_IDLE;
            op <= pfc_pkg::PFC_OP_READ;
            cnt <= 6'h00;
            step <= 3'h0;
            addr <= 16'h0000;
            data <= 16'h0000;
            prev6 <= 1'b0;
            have_prev <= 1'b0;
            fin <= 1'b0;
            id_mode <= 1'b0;
            done <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
            pin_addr <= 16'h0000;
            pin_dq <= 16'h0000;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            dq_oe <= 1'b0;
        end else begin
            state <= next_state;
            op <= next_op;
            cnt <= next_cnt;
            step <= next_step;
            addr <= next_addr;
            data <= next_data;
            prev6 <= next_prev6;
            have_prev <= next_have_prev;
            fin <= next_fin;
            id_mode <= next_id_mode;
            done <= next_done;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            pin_addr <= next_pin_addr;
            pin_dq <= next_pin_dq;
            ce_n <= next_ce_n;
            oe_n <= next_oe_n;
            we_n <= next_we_n;
            dq_oe <= next_dq_oe;
        end
    end

    assign CMD_READY = (state == pfc_pkg::PFC_ST_IDLE);
    assign CMD_DONE = done;
    assign RSP_VALID = rsp_valid;
    assign RSP_DATA = rsp_data;
    assign ID_MODE = id_mode;
    assign FL_ADDR = pin_addr;
    assign FL_DQ_OUT = pin_dq;
    assign FL_DQ_OE = dq_oe;
    assign FL_CE_N = ce_n;
    assign FL_OE_N = oe_n;
    assign FL_WE_N = we_n;

    // helper: run lengths of write-low and output-enable-high phases
    logic [7:0] we_lo_len;
    logic [7:0] oe_hi_len;
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            we_lo_len <= 8'h00;
            oe_hi_len <= 8'hFF;
        end else begin
            we_lo_len <= FL_WE_N ? 8'h00 : we_lo_len + {7'h00, we_lo_len != 8'hFF};
            oe_hi_len <= !FL_OE_N ? 8'h00 : oe_hi_len + {7'h00, oe_hi_len != 8'hFF};
        end
    end

    a_oe_during_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (!FL_WE_N && !FL_CE_N) |-> FL_OE_N) else $error("output enable low during write");
    a_we_low_width: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(FL_WE_N) |-> we_lo_len >= 8'(`PFC_WP_CYC)) else $error("write pulse too short");
    a_oe_high_pulse: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $fell(FL_OE_N) |-> oe_hi_len >= 8'(`PFC_TOGGLE_HI_CYC)) else $error("read high phase too short");
    a_cmd_upper_zero: assert property (@(posedge CLOCK) disable iff (!RST_N)
        ($fell(FL_WE_N) && !(op == pfc_pkg::PFC_OP_PROG && step == 3'h3))
        |-> (FL_ADDR[15:12] == 4'h0 && FL_DQ_OUT[15:8] == 8'h00)) else $error("command upper bits set");
    a_id_entry_mode: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(ID_MODE) |-> ($past(op) == pfc_pkg::PFC_OP_ID_ENTRY && $past(pin_dq[7:0]) == `PFC_DAT_ID_ENTRY))
        else $error("identification mode without entry");
    a_id_exit_mode: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $fell(ID_MODE) |-> $past(op) == pfc_pkg::PFC_OP_ID_EXIT) else $error("identification left without exit");
    a_poll_addr_fixed: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (poll_op && state == pfc_pkg::PFC_ST_RD_HI) ##1 (state == pfc_pkg::PFC_ST_RD_LO) |-> $stable(FL_ADDR))
        else $error("poll address moved");
    a_id_read_addr: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (op == pfc_pkg::PFC_OP_ID_READ && !FL_OE_N) |-> FL_ADDR[15:1] == 15'h0000) else $error("bad id address");
    a_erase_final: assert property (@(posedge CLOCK) disable iff (!RST_N)
        ($fell(FL_WE_N) && step == 3'h5 && op == pfc_pkg::PFC_OP_CHIP_ERASE) |-> FL_DQ_OUT[7:0] == 8'h10)
        else $error("wrong erase value");
    a_poll_done: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (CMD_DONE && poll_op) |-> (have_prev && RSP_DATA[`PFC_TOGGLE_BIT] == prev6 && fin))
        else $error("poll finished early");
endmodule : pfc_host

/* File: tb/pfc_flash_model.sv */
/*
 * Behavioural model of the 16-bit parallel flash on the host pins.
 * Assumes the bench resolves the shared data bus and feeds it to dq_in.
 */
`timescale 1ns/100ps

module pfc_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00A5, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h005A, // arbitrary value
    parameter int BUSY_READS = 3
) (
    input wire logic [15:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output int violations
);
    logic [15:0] mem [0:65535];
    logic [2:0] step;
    logic id_mode;
    logic tgl;
    logic poll_set;
    logic [15:0] poll_addr;
    logic [15:0] last;
    int busy;
    realtime t_fall;
    realtime t_rd_end;
    wire strobe_n = ce_n | we_n;
    wire rd_en = !ce_n && !oe_n && we_n;

    initial begin
        for (int k = 0; k < 65536; k++) mem[k] = 16'hFFFF;
        id_mode = 1'b0;
        step = 3'h0;
        tgl = 1'b0;
        poll_set = 1'b0;
        busy = 0;
        violations = 0;
        last = 16'h0000;
        dq_out = 16'h5A5A;
        t_fall = -1.0;
        t_rd_end = -1000.0;
    end

    task automatic write_cycle(input logic [15:0] fa, input logic [15:0] d);
        logic c555;
        logic c2aa;
        logic [7:0] cd;
        cd = d[7:0];
        c555 = (fa[11:0] == 12'h555);
        c2aa = (fa[10:0] == 11'h2AA);
        if (cd == 8'hF0 && step != 3'h3) begin
            id_mode = 1'b0;
            step = 3'h0;
        end else begin
            case (step)
                3'h0: step = (c555 && cd == 8'hAA) ? 3'h1 : 3'h0;
                3'h1: step = (c2aa && cd == 8'h55) ? 3'h2 : 3'h0;
                3'h2: begin
                    if (c555 && cd == 8'h90) id_mode = 1'b1;
                    step = (c555 && cd == 8'hA0) ? 3'h3 : (c555 && cd == 8'h80) ? 3'h4 : 3'h0;
                end
                3'h3: begin
                    mem[fa] = d;
                    busy = BUSY_READS;
                    step = 3'h0;
                end
                3'h4: step = (c555 && cd == 8'hAA) ? 3'h5 : 3'h0;
                3'h5: step = (c2aa && cd == 8'h55) ? 3'h6 : 3'h0;
                default: begin
                    if (c555 && (cd == 8'h10 || cd == 8'h30)) begin
                        for (int k = (cd == 8'h10) ? 0 : 32'h2000; k < 65536; k++) mem[k] = 16'hFFFF;
                        busy = BUSY_READS;
                    end
                    step = 3'h0;
                end
            endcase
        end
    endtask : write_cycle

    always @(negedge strobe_n) begin
        t_fall = $realtime;
        if (oe_n !== 1'b1) violations++;
    end

    always @(negedge oe_n) begin
        if (strobe_n === 1'b0) violations++;
    end

    always @(posedge strobe_n) begin
        if (t_fall >= 0.0 && $realtime - t_fall < 50.0) violations++;
        else if (t_fall >= 0.0) write_cycle(addr, dq_in);
        t_fall = -1.0;
    end

    // address pins change in the same step as the enables: let them settle
    always @(posedge rd_en) begin
        if ($realtime - t_rd_end < 150.0) violations++;
        #1;
        if (busy > 0) begin
            if (poll_set && addr !== poll_addr) violations++;
            poll_addr = addr;
            poll_set = 1'b1;
            tgl = ~tgl;
            busy--;
            last = {mem[addr][15:7], tgl, mem[addr][5:0]};
        end else begin
            poll_set = 1'b0;
            last = (id_mode && addr[15:1] == 15'h0) ? (addr[0] ? PART_CODE : MAKER_CODE) : mem[addr];
        end
        dq_out = last;
    end

    always @(negedge rd_en) begin
        t_rd_end = $realtime;
        dq_out = ~last;
    end
endmodule : pfc_flash_model

/* File: tb/test_parallel_flash_command_port.sv */
/*
 * Self-checking bench of the flash command port host against the flash model.
 * Assumes pfc_pkg and pfc_host compiled first.
 */
`timescale 1ns/100ps

module test_parallel_flash_command_port;
    localparam logic [15:0] MAKER = 16'h00A5;
    localparam logic [15:0] PART = 16'h005A;
    logic CLOCK;
    logic RST_N;
    logic CMD_VALID;
    logic CMD_READY;
    pfc_pkg::pfc_op_type CMD_OP;
    logic [15:0] CMD_ADDR;
    logic [15:0] CMD_DATA;
    logic CMD_DONE;
    logic RSP_VALID;
    logic [15:0] RSP_DATA;
    logic ID_MODE;
    logic [15:0] FL_ADDR;
    logic FL_CE_N;
    logic FL_OE_N;
    logic FL_WE_N;
    logic [15:0] FL_DQ_OUT;
    logic FL_DQ_OE;
    logic [15:0] model_dq;
    logic [15:0] bus;
    logic [15:0] exp_q [$];
    logic [15:0] main_addr;
    logic [15:0] main_data;
    logic [15:0] boot_addr;
    logic [15:0] boot_data;
    int violations;
    int err_total;
    int checked;
    int seed_dummy;

    assign bus = FL_DQ_OE ? FL_DQ_OUT : model_dq;

    pfc_host pfc_host_i (.CLOCK(CLOCK), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
        .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .CMD_DONE(CMD_DONE),
        .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .ID_MODE(ID_MODE), .FL_ADDR(FL_ADDR),
        .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_DQ_IN(bus),
        .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE));

    pfc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BUSY_READS(3)) pfc_flash_model_i (
        .addr(FL_ADDR), .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N), .dq_in(bus),
        .dq_out(model_dq), .violations(violations));

    task automatic compare_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : compare_val

    task automatic print_verdict;
        if (err_total == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic run_op(input pfc_pkg::pfc_op_type op, input logic [15:0] a, input logic [15:0] d);
        int n;
        CMD_OP <= op;
        CMD_ADDR <= a;
        CMD_DATA <= d;
        CMD_VALID <= 1'b1;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (CMD_READY !== 1'b1 && n < 100);
        if (CMD_READY !== 1'b1) begin
            err_total++;
            print_verdict();
        end
        CMD_VALID <= 1'b0;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (CMD_DONE !== 1'b1 && n < 5000);
        if (CMD_DONE !== 1'b1) begin
            err_total++;
            print_verdict();
        end
    endtask : run_op

    task automatic read_exp(input pfc_pkg::pfc_op_type op, input logic [15:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        run_op(op, a, 16'($urandom));
    endtask : read_exp

    always @(posedge CLOCK) begin
        if (RST_N === 1'b1 && RSP_VALID === 1'b1) begin
            if (exp_q.size() == 0) compare_val("rsp_queue_fill", 16'h0001, 16'h0000);
            else compare_val("rsp_data", exp_q.pop_front(), RSP_DATA);
        end
    end

    initial begin
        CLOCK = 1'b0;
        forever #2 CLOCK = ~CLOCK;
    end

    initial begin
        RST_N = 1'b0;
        CMD_VALID = 1'b0;
        CMD_OP = pfc_pkg::PFC_OP_READ;
        CMD_ADDR = 16'h0000;
        CMD_DATA = 16'h0000;
        err_total = 0;
        checked = 0;
        seed_dummy = $urandom(32'h03AB);
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        compare_val("idle_pins", 16'h0039, {10'h000, FL_CE_N, FL_OE_N, FL_WE_N, FL_DQ_OE, ID_MODE, CMD_READY});
        for (int i = 0; i < 3; i++) begin
            main_addr = 16'h2000 + 16'($urandom % 32'hE000);
            main_data = 16'($urandom);
            run_op(pfc_pkg::PFC_OP_PROG, main_addr, main_data);
            read_exp(pfc_pkg::PFC_OP_READ, main_addr, main_data);
        end
        boot_addr = 16'($urandom % 32'h2000);
        boot_data = 16'($urandom);
        run_op(pfc_pkg::PFC_OP_PROG, boot_addr, boot_data);
        run_op(pfc_pkg::PFC_OP_ID_ENTRY, 16'($urandom), 16'($urandom));
        compare_val("id_mode_on", 16'h0001, {15'h0000, ID_MODE});
        read_exp(pfc_pkg::PFC_OP_ID_READ, 16'($urandom) & 16'hFFFE, MAKER);
        read_exp(pfc_pkg::PFC_OP_ID_READ, 16'($urandom) | 16'h0001, PART);
        run_op(pfc_pkg::PFC_OP_ID_EXIT, 16'($urandom), 16'($urandom));
        compare_val("id_mode_off", 16'h0000, {15'h0000, ID_MODE});
        read_exp(pfc_pkg::PFC_OP_READ, main_addr, main_data);
        run_op(pfc_pkg::PFC_OP_MAIN_ERASE, main_addr, 16'h0000);
        read_exp(pfc_pkg::PFC_OP_READ, main_addr, 16'hFFFF);
        read_exp(pfc_pkg::PFC_OP_READ, boot_addr, boot_data);
        run_op(pfc_pkg::PFC_OP_CHIP_ERASE, boot_addr, 16'h0000);
        read_exp(pfc_pkg::PFC_OP_READ, boot_addr, 16'hFFFF);
        @(posedge CLOCK);
        compare_val("model_violations", 16'h0000, violations[15:0]);
        compare_val("rsp_left", 16'h0000, 16'(exp_q.size()));
        print_verdict();
    end
endmodule : test_parallel_flash_command_port
